// file: rtl/bbsf_pkg.sv
// Package of constants and types for the buck-boost setpoint and fault logic
package bbsf_pkg;
    // Setpoint mapping in millivolts
    localparam int unsigned BB_BASE_MV      = 9600;
    localparam int unsigned BB_STEP_MV      = 50;
    localparam int unsigned BO_BASE_MV      = 1000;
    localparam int unsigned BO_STEP_MV      = 25;
    localparam int unsigned CODE_W          = 7;
    localparam int unsigned MV_W            = 14;
    localparam logic [6:0]  CODE_RESET      = 7'h30;
    // Peak current limits in milliamps
    localparam logic [11:0] PEAK_CURRENT_LIMIT_SELECT_MA_00      = 12'h4B0;
    localparam logic [11:0] PEAK_CURRENT_LIMIT_SELECT_MA_01      = 12'h6A4;
    localparam logic [11:0] PEAK_CURRENT_LIMIT_SELECT_MA_10      = 12'h834;
    localparam logic [11:0] PEAK_CURRENT_LIMIT_SELECT_MA_11      = 12'h9C4;
    localparam logic [1:0]  PEAK_CURRENT_LIMIT_SELECT_RESET      = 2'h3;
    localparam int unsigned CURR_W          = 12;
    // Warning 80 percent, short 125 percent, as ratios
    localparam int unsigned WARN_NUM        = 4;
    localparam int unsigned WARN_DEN        = 5;
    localparam int unsigned SHORT_NUM       = 5;
    localparam int unsigned SHORT_DEN       = 4;
    // Consecutive switching cycles
    localparam logic [4:0]  CONSEC_CYCLES   = 5'h10;
    // Timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned RETRY_MS        = 14;
    localparam int unsigned RESTART_MS      = 100;
    localparam int unsigned RETRY_CYCLES    = RETRY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned RESTART_CYCLES  = RESTART_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W         = 24;
    // Fault states
    typedef enum logic [1:0] {ST_RUN, ST_RETRY, ST_GLOBAL} bbsf_state_type;
endpackage

// file: rtl/bbsf_core.sv
// Setpoint decode, current fault supervision and power-good latch of the buck-boost
`timescale 1ns/1ps
module bbsf_core #(
    parameter int unsigned RETRY_COUNT   = bbsf_pkg::RETRY_CYCLES,
    parameter int unsigned RESTART_COUNT = bbsf_pkg::RESTART_CYCLES
) (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    // Factory configuration
    input  wire logic                           factoryBuckOnly,
    // Register access
    input  wire logic                           codeWrite,
    input  wire logic [bbsf_pkg::CODE_W-1:0]    codeWriteData,
    input  wire logic                           limitWrite,
    input  wire logic [1:0]                     limitWriteData,
    input  wire logic                           maskWrite,
    input  wire logic [3:0]                     maskWriteData,
    input  wire logic                           powerGoodRead,
    input  wire logic                           warningRead,
    input  wire logic                           regulatorOn,
    // Analog sense
    input  wire logic                           cycleStart,
    input  wire logic [bbsf_pkg::CURR_W-1:0]    peakCurrent,
    input  wire logic                           outputBelowThreshold,
    input  wire logic                           gpioRoutePowerGood,
    // Outputs
    output logic [bbsf_pkg::CODE_W-1:0]         output_voltage_code,
    output logic [1:0]                          peak_current_limit_select,
    output logic [bbsf_pkg::MV_W-1:0]           targetMillivolts,
    output logic [bbsf_pkg::CURR_W-1:0]         programmed_current_threshold,
    output logic                                switchOff,
    output logic                                supplyEnable,
    output logic                                global_fault_state,
    output logic                                current_warning_flag,
    output logic                                currentFaultFlag,
    output logic                                shortFlag,
    output logic                                output_power_good,
    output logic                                gpioOut,
    output logic                                interrupt_request_n,
    output logic [3:0]                          maskState
);
    import bbsf_pkg::*;

    function automatic logic [CURR_W-1:0] limitMa(input logic [1:0] sel);
        case (sel)
            2'h0:    limitMa = PEAK_CURRENT_LIMIT_SELECT_MA_00;
            2'h1:    limitMa = PEAK_CURRENT_LIMIT_SELECT_MA_01;
            2'h2:    limitMa = PEAK_CURRENT_LIMIT_SELECT_MA_10;
            default: limitMa = PEAK_CURRENT_LIMIT_SELECT_MA_11;
        endcase
    endfunction

    logic                current_warning_irq_mask;
    logic                current_fault_irq_mask;
    logic                shutIrqMask;
    logic                power_good_fault_unmask;
    logic [4:0]          warnCount;
    logic [4:0]          limitCount;
    logic [TIMER_W-1:0]  timer;
    logic                powerGoodIrq;
    bbsf_state_type      state;
    logic [CURR_W+2:0]   peakScaled;
    logic                atWarn;
    logic                atLimit;
    logic                atShort;
    logic [MV_W-1:0]     next_target;

    assign {power_good_fault_unmask, shutIrqMask, current_fault_irq_mask, current_warning_irq_mask} = maskState;

    // Threshold compares; warning and short in scaled current, limit unscaled
    always_comb
    begin
        peakScaled = {3'h0, peakCurrent};
        atWarn  = (peakScaled * (CURR_W+3)'(WARN_DEN)) >=
                  ({3'h0, programmed_current_threshold} * (CURR_W+3)'(WARN_NUM));
        atLimit = peakCurrent >= programmed_current_threshold;
        atShort = (peakScaled * (CURR_W+3)'(SHORT_DEN)) >=
                  ({3'h0, programmed_current_threshold} * (CURR_W+3)'(SHORT_NUM));
        if (factoryBuckOnly)
            next_target = MV_W'(BO_BASE_MV) + MV_W'(output_voltage_code) * MV_W'(BO_STEP_MV);
        else
            next_target = MV_W'(BB_BASE_MV) + MV_W'(output_voltage_code) * MV_W'(BB_STEP_MV);
    end

    // Static registers; code only changes by write
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            output_voltage_code       <= CODE_RESET;
            peak_current_limit_select <= PEAK_CURRENT_LIMIT_SELECT_RESET;
            maskState                 <= 4'h0;
        end
        else
        begin
            if (codeWrite)
                output_voltage_code <= codeWriteData;
            if (limitWrite)
                peak_current_limit_select <= limitWriteData;
            if (maskWrite)
                maskState <= maskWriteData;
        end
    end

    // Decoded targets
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            targetMillivolts             <= '0;
            programmed_current_threshold <= PEAK_CURRENT_LIMIT_SELECT_MA_11;
        end
        else
        begin
            targetMillivolts             <= next_target;
            programmed_current_threshold <= limitMa(peak_current_limit_select);
        end
    end

    // Cycle-by-cycle limit
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            switchOff <= 1'b0;
        else if (cycleStart)
            switchOff <= 1'b0;
        else if (atLimit)
            switchOff <= 1'b1;
    end

    // Consecutive cycle counters
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            warnCount  <= 5'h0;
            limitCount <= 5'h0;
        end
        else if (cycleStart)
        begin
            warnCount  <= atWarn ? ((warnCount == CONSEC_CYCLES) ? warnCount : warnCount + 5'h1) : 5'h0;
            limitCount <= atLimit ? ((limitCount == CONSEC_CYCLES) ? limitCount : limitCount + 5'h1) : 5'h0;
        end
    end

    // Sticky warning and fault flags, set wins over read clear
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            current_warning_flag <= 1'b0;
            currentFaultFlag     <= 1'b0;
        end
        else
        begin
            if (warnCount == CONSEC_CYCLES && !current_warning_irq_mask)
                current_warning_flag <= 1'b1;
            else if (warningRead)
                current_warning_flag <= 1'b0;
            if (limitCount == CONSEC_CYCLES && !current_fault_irq_mask)
                currentFaultFlag <= 1'b1;
            else if (warningRead)
                currentFaultFlag <= 1'b0;
        end
    end

    // Short circuit, retry and global restart sequencing
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state              <= ST_RUN;
            timer              <= '0;
            supplyEnable       <= 1'b1;
            global_fault_state <= 1'b0;
            shortFlag          <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (atShort && supplyEnable)
                    begin
                        supplyEnable <= 1'b0;
                        timer        <= '0;
                        shortFlag    <= !shutIrqMask;
                        global_fault_state <= !shutIrqMask;
                        state        <= shutIrqMask ? ST_RETRY : ST_GLOBAL;
                    end
                    else if (warningRead)
                        shortFlag <= 1'b0;
                end
                ST_RETRY:
                begin
                    timer <= timer + 1'b1;
                    if (timer == TIMER_W'(RETRY_COUNT - 1))
                    begin
                        supplyEnable <= 1'b1;
                        state        <= ST_RUN;
                    end
                end
                ST_GLOBAL:
                begin
                    timer <= timer + 1'b1;
                    if (timer == TIMER_W'(RESTART_COUNT - 1))
                    begin
                        supplyEnable       <= 1'b1;
                        global_fault_state <= 1'b0;
                        state              <= ST_RUN;
                    end
                end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    // Power-good latch and its interrupt
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            output_power_good <= 1'b1;
            powerGoodIrq      <= 1'b0;
            gpioOut           <= 1'b0;
        end
        else
        begin
            if (outputBelowThreshold)
                output_power_good <= 1'b0;
            else if (powerGoodRead)
                output_power_good <= 1'b1;
            if (!regulatorOn)
                powerGoodIrq <= 1'b0;
            else if (outputBelowThreshold && power_good_fault_unmask)
                powerGoodIrq <= 1'b1;
            else if (powerGoodRead && !outputBelowThreshold)
                powerGoodIrq <= 1'b0;
            gpioOut <= gpioRoutePowerGood & output_power_good;
        end
    end

    // Interrupt line
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            interrupt_request_n <= 1'b1;
        else
            interrupt_request_n <= !(current_warning_flag | currentFaultFlag | shortFlag | powerGoodIrq);
    end

    AST_WARN_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (warnCount == CONSEC_CYCLES && !current_warning_irq_mask) |=> current_warning_flag ##1 !interrupt_request_n)
        else $error("warning flag did not set");
    AST_FAULT_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (limitCount == CONSEC_CYCLES && !current_fault_irq_mask) |=> ##1 !interrupt_request_n)
        else $error("current fault did not interrupt");
    AST_LIMIT_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        (atLimit && !cycleStart) |=> switchOff)
        else $error("switch not turned off at limit");
    AST_SHORT_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_RUN && atShort && supplyEnable) |=> !supplyEnable)
        else $error("short did not shut supply");
    sequence seqRetryStart;
        state == ST_RUN ##1 state == ST_RETRY;
    endsequence
    AST_RETRY_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        seqRetryStart |-> !supplyEnable)
        else $error("supply on during retry wait");
    AST_GLOBAL_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_GLOBAL) |-> global_fault_state && !supplyEnable)
        else $error("global fault state mismatch");
    AST_PG_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!output_power_good && !powerGoodRead) |=> !output_power_good)
        else $error("power good released without read");
    AST_PG_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        outputBelowThreshold |=> !output_power_good)
        else $error("power good not cleared");
    AST_PG_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!powerGoodIrq && !power_good_fault_unmask) |=> !powerGoodIrq)
        else $error("masked power good raised interrupt");
    AST_TARGET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!factoryBuckOnly && $stable(output_voltage_code))
        |=> targetMillivolts == MV_W'(BB_BASE_MV) + MV_W'($past(output_voltage_code)) * MV_W'(BB_STEP_MV))
        else $error("buck-boost target wrong");
endmodule

// file: verification/bbsf_host_model.sv
// Host processor model that issues register strobes
`timescale 1ns/1ps
module bbsf_host_model (
    // Clock
    input  wire logic                         core_clk,
    // Register strobes
    output logic                              codeWrite,
    output logic [bbsf_pkg::CODE_W-1:0]       codeWriteData,
    output logic                              limitWrite,
    output logic [1:0]                        limitWriteData,
    output logic                              maskWrite,
    output logic [3:0]                        maskWriteData,
    output logic                              powerGoodRead,
    output logic                              warningRead
);
    import bbsf_pkg::*;
    initial
    begin
        {codeWrite, limitWrite, maskWrite, powerGoodRead, warningRead} = 5'h00;
        codeWriteData  = 7'h00;
        limitWriteData = 2'h0;
        maskWriteData  = 4'h0;
    end
    // Drives the selected strobe line
    task automatic set_strobe(input int sel, input logic v);
        case (sel)
            0:       codeWrite = v;
            1:       limitWrite = v;
            2:       maskWrite = v;
            3:       powerGoodRead = v;
            default: warningRead = v;
        endcase
    endtask
    // One strobe cycle, launched and dropped at falling edges
    task automatic strobe(input int sel);
        set_strobe(sel, 1'b1);
        @(negedge core_clk);
        set_strobe(sel, 1'b0);
        @(negedge core_clk);
    endtask
    task automatic write_code(input logic [6:0] v);
        codeWriteData = v;
        strobe(0);
    endtask
    task automatic write_limit(input logic [1:0] v);
        limitWriteData = v;
        strobe(1);
    endtask
    task automatic write_mask(input logic [3:0] v);
        maskWriteData = v;
        strobe(2);
    endtask
    task automatic read_pg();
        strobe(3);
    endtask
    task automatic read_flags();
        strobe(4);
    endtask
endmodule

// file: verification/tb_top.sv
// Self-checking testbench of the setpoint and fault logic
`timescale 1ns/1ps
module tb_top;
    import bbsf_pkg::*;
    localparam int unsigned RETRY_SIM   = 20;
    localparam int unsigned RESTART_SIM = 50;
    logic                core_clk;
    logic                rst_n;
    logic                factoryBuckOnly;
    logic                codeWrite;
    logic [6:0]          codeWriteData;
    logic                limitWrite;
    logic [1:0]          limitWriteData;
    logic                maskWrite;
    logic [3:0]          maskWriteData;
    logic                powerGoodRead;
    logic                warningRead;
    logic                regulatorOn;
    logic                cycleStart;
    logic [11:0]         peakCurrent;
    logic                outputBelowThreshold;
    logic                gpioRoutePowerGood;
    logic [6:0]          output_voltage_code;
    logic [1:0]          peak_current_limit_select;
    logic [13:0]         targetMillivolts;
    logic [11:0]         programmed_current_threshold;
    logic                switchOff;
    logic                supplyEnable;
    logic                global_fault_state;
    logic                current_warning_flag;
    logic                currentFaultFlag;
    logic                shortFlag;
    logic                output_power_good;
    logic                gpioOut;
    logic                interrupt_request_n;
    logic [3:0]          maskState;
    int                  fails;
    int                  checks;
    logic [11:0]         limTable [4];

    bbsf_core #(.RETRY_COUNT(RETRY_SIM), .RESTART_COUNT(RESTART_SIM)) i_bbsf_core (
        .core_clk(core_clk), .rst_n(rst_n), .factoryBuckOnly(factoryBuckOnly),
        .codeWrite(codeWrite), .codeWriteData(codeWriteData), .limitWrite(limitWrite),
        .limitWriteData(limitWriteData), .maskWrite(maskWrite), .maskWriteData(maskWriteData),
        .powerGoodRead(powerGoodRead), .warningRead(warningRead), .regulatorOn(regulatorOn),
        .cycleStart(cycleStart), .peakCurrent(peakCurrent), .outputBelowThreshold(outputBelowThreshold),
        .gpioRoutePowerGood(gpioRoutePowerGood), .output_voltage_code(output_voltage_code),
        .peak_current_limit_select(peak_current_limit_select), .targetMillivolts(targetMillivolts),
        .programmed_current_threshold(programmed_current_threshold), .switchOff(switchOff),
        .supplyEnable(supplyEnable), .global_fault_state(global_fault_state),
        .current_warning_flag(current_warning_flag), .currentFaultFlag(currentFaultFlag),
        .shortFlag(shortFlag), .output_power_good(output_power_good), .gpioOut(gpioOut),
        .interrupt_request_n(interrupt_request_n), .maskState(maskState));
    bbsf_host_model i_bbsf_host_model (.core_clk(core_clk), .codeWrite(codeWrite), .codeWriteData(codeWriteData),
        .limitWrite(limitWrite), .limitWriteData(limitWriteData), .maskWrite(maskWrite),
        .maskWriteData(maskWriteData), .powerGoodRead(powerGoodRead), .warningRead(warningRead));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            cycleStart = 1'b1;
            idle(1);
            cycleStart = 1'b0;
            idle(1);
        end
    endtask
    task automatic do_reset(input logic buckOnly);
        rst_n = 1'b0;
        factoryBuckOnly = buckOnly;
        idle(20);
        rst_n = 1'b1;
        idle(2);
    endtask
    task automatic wait_supply(input int lo, input int hi);
        int n;
        n = 0;
        while (supplyEnable !== 1'b1 && n < 200)
        begin
            idle(1);
            n++;
        end
        if (n >= 200)
        begin
            fails++;
            $display("CHECK FAILED at %0t: supply never restarted", $time);
            print_verdict();
        end
        chk(16'(n >= lo && n <= hi), 16'h1, "restart delay");
    endtask

    task automatic t_reset_values();
        chk(16'(output_voltage_code), 16'(CODE_RESET), "code reset");
        chk(16'(programmed_current_threshold), 16'(PEAK_CURRENT_LIMIT_SELECT_MA_11), "limit reset");
        chk(16'(targetMillivolts), 16'(BB_BASE_MV + CODE_RESET * BB_STEP_MV), "target reset");
        chk(16'({supplyEnable, global_fault_state, interrupt_request_n, output_power_good}), 16'hB, "status");
    endtask
    task automatic t_setpoint();
        logic [6:0] codes [3];
        codes = '{7'h00, 7'h7F, 7'h30};
        foreach (codes[i])
        begin
            i_bbsf_host_model.write_code(codes[i]);
            idle(2);
            chk(16'(output_voltage_code), 16'(codes[i]), "code");
            chk(16'(targetMillivolts), 16'(BB_BASE_MV + codes[i] * BB_STEP_MV), "bb target");
        end
        i_bbsf_host_model.write_limit(2'h1);
        idle(10);
        chk(16'(targetMillivolts), 16'(BB_BASE_MV + 48 * BB_STEP_MV), "static target");
    endtask
    task automatic t_limits();
        limTable = '{PEAK_CURRENT_LIMIT_SELECT_MA_00, PEAK_CURRENT_LIMIT_SELECT_MA_01, PEAK_CURRENT_LIMIT_SELECT_MA_10, PEAK_CURRENT_LIMIT_SELECT_MA_11};
        for (int i = 0; i < 4; i++)
        begin
            i_bbsf_host_model.write_limit(2'(i));
            idle(1);
            chk(16'(peak_current_limit_select), 16'(i), "limit select");
            chk(16'(programmed_current_threshold), 16'(limTable[i]), "threshold");
        end
    endtask
    task automatic t_warning();
        i_bbsf_host_model.write_mask(4'h0);
        peakCurrent = 12'(PEAK_CURRENT_LIMIT_SELECT_MA_11 * WARN_NUM / WARN_DEN);
        pulse(15);
        chk(16'(current_warning_flag), 16'h0, "warn early");
        chk(16'(switchOff), 16'h0, "no limit");
        pulse(1);
        chk(16'(current_warning_flag), 16'h1, "warn set");
        idle(1);
        chk(16'(interrupt_request_n), 16'h0, "warn irq");
        peakCurrent = 12'h000;
        pulse(1);
        i_bbsf_host_model.read_flags();
        idle(2);
        chk(16'({current_warning_flag, interrupt_request_n}), 16'h1, "warn cleared");
        i_bbsf_host_model.write_mask(4'h1);
        peakCurrent = 12'(PEAK_CURRENT_LIMIT_SELECT_MA_11 * WARN_NUM / WARN_DEN);
        pulse(16);
        idle(2);
        chk(16'({current_warning_flag, interrupt_request_n}), 16'h1, "warn masked");
        peakCurrent = 12'h000;
        pulse(1);
    endtask
    task automatic t_fault(input logic [3:0] mask, input logic expIrq);
        i_bbsf_host_model.write_mask(mask);
        chk(16'(maskState), 16'(mask), "mask");
        peakCurrent = PEAK_CURRENT_LIMIT_SELECT_MA_11;
        pulse(1);
        chk(16'(switchOff), 16'h1, "cycle limit");
        pulse(14);
        chk(16'(currentFaultFlag), 16'h0, "fault early");
        pulse(1);
        idle(1);
        chk(16'({currentFaultFlag, interrupt_request_n}), {14'h0, expIrq, ~expIrq}, "fault");
        peakCurrent = 12'h000;
        pulse(1);
        chk(16'(switchOff), 16'h0, "limit released");
        i_bbsf_host_model.read_flags();
        idle(2);
        chk(16'(interrupt_request_n), 16'h1, "fault cleared");
    endtask
    task automatic t_short(input logic [3:0] mask, input logic global, input int count);
        i_bbsf_host_model.write_mask(mask);
        peakCurrent = 12'(PEAK_CURRENT_LIMIT_SELECT_MA_11 * SHORT_NUM / SHORT_DEN);
        idle(1);
        peakCurrent = 12'h000;
        chk(16'({supplyEnable, global_fault_state, shortFlag}), {13'h0, 1'b0, global, global}, "shutdown");
        idle(1);
        chk(16'(interrupt_request_n), 16'(!global), "short irq");
        wait_supply(count - 3, count + 3);
        chk(16'(global_fault_state), 16'h0, "restarted");
        i_bbsf_host_model.read_flags();
        idle(2);
    endtask
    task automatic t_power_good();
        i_bbsf_host_model.write_mask(4'h8);
        outputBelowThreshold = 1'b1;
        idle(3);
        chk(16'({output_power_good, gpioOut, interrupt_request_n}), 16'h0, "pg fault");
        outputBelowThreshold = 1'b0;
        idle(3);
        chk(16'({output_power_good, interrupt_request_n}), 16'h0, "pg latched");
        i_bbsf_host_model.read_pg();
        idle(2);
        chk(16'({output_power_good, gpioOut, interrupt_request_n}), 16'h7, "pg read");
        outputBelowThreshold = 1'b1;
        idle(3);
        regulatorOn = 1'b0;
        idle(2);
        chk(16'(interrupt_request_n), 16'h1, "off clears");
        outputBelowThreshold = 1'b0;
        regulatorOn = 1'b1;
        i_bbsf_host_model.read_pg();
        i_bbsf_host_model.write_mask(4'h0);
        outputBelowThreshold = 1'b1;
        idle(3);
        chk(16'({output_power_good, interrupt_request_n}), 16'h1, "pg suppressed");
        outputBelowThreshold = 1'b0;
        i_bbsf_host_model.read_pg();
        idle(2);
        chk(16'(output_power_good), 16'h1, "pg back");
        gpioRoutePowerGood = 1'b0;
        idle(2);
        chk(16'({output_power_good, gpioOut}), 16'h2, "gpio unrouted");
        gpioRoutePowerGood = 1'b1;
    endtask
    task automatic t_buck_only();
        i_bbsf_host_model.write_code(7'h20);
        idle(2);
        chk(16'(targetMillivolts), 16'(BO_BASE_MV + 32 * BO_STEP_MV), "bo target");
        i_bbsf_host_model.write_code(7'h7F);
        idle(2);
        chk(16'(targetMillivolts), 16'(BO_BASE_MV + 127 * BO_STEP_MV), "bo top");
    endtask

    initial
    begin
        fails = 0;
        checks = 0;
        rst_n = 1'b0;
        factoryBuckOnly = 1'b0;
        regulatorOn = 1'b1;
        cycleStart = 1'b0;
        peakCurrent = 12'h000;
        outputBelowThreshold = 1'b0;
        gpioRoutePowerGood = 1'b1;
        do_reset(1'b0);
        t_reset_values();
        t_setpoint();
        t_limits();
        t_warning();
        t_fault(4'h1, 1'b1);
        t_fault(4'h3, 1'b0);
        t_short(4'h4, 1'b0, RETRY_SIM);
        t_short(4'h0, 1'b1, RESTART_SIM);
        t_power_good();
        do_reset(1'b1);
        t_buck_only();
        print_verdict();
    end
endmodule
